// *** shared/dacbuf_pkg.sv ***
// Purpose: Constants, register map and types for the buffered DAC control
// Assumes: 32-bit APB-style peripheral bus, byte addresses, 50 MHz clock
// Notes: Rule overview follows; widths are fixed
//
// Overview of operation
// - Soft reset bit returns every register to reset value, controller disabled
// - Analog output pin driver active only while external output enable is one
// - Reference select chooses internal (default), analog supply or external
// - Every load of the live data register while enabled starts a conversion at once
// - Live data loads from bus write, DMA write, or staged buffer on start
// - Start event moves staged value buffer into live data and converts
// - Buffer-empty DMA request sets on transfer, clears on buffer or flag write
// - Staged buffer starts empty so enabling raises a DMA request
// - Buffer-empty flag sets when a start event takes the buffer value or enabling finds the buffer empty
// - Underrun flag sets when start event meets an empty internal buffer
// - Each source has a flag; enable-set writes enable, enable-clear disables
// - Enable-set and enable-clear registers show one shared enable state
// - Enable-clear bit1 empty, bit0 underrun; one clears, read shows enable

package dacbuf_pkg;

  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam int DATA_W = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL_A = 8'h00;
  localparam logic [7:0] OFF_INTEN_CLEAR = 8'h04;
  localparam logic [7:0] OFF_INTEN_SET = 8'h08;
  localparam logic [7:0] OFF_INT_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_CONTROL_B = 8'h10;
  localparam logic [7:0] OFF_LIVE_DATA = 8'h14;
  localparam logic [7:0] OFF_STAGED_BUF = 8'h18;

  // Field positions
  localparam int CTLA_SOFT_RESET_BIT = 0;
  localparam int CTLA_ENABLE_BIT = 1;
  localparam int CTLB_EXTERNAL_OUTPUT_ENABLE_BIT = 0;
  localparam int CTLB_REFERENCE_SELECT_LSB = 2;
  localparam int INT_UNDERRUN_BIT = 0;
  localparam int INT_EMPTY_BIT = 1;
  localparam int INT_W = 2;

  // Reset values
  localparam logic [INT_W-1:0] INT_RESET = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;
  localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_FULL_SCALE = 10'h3FF;

  // Reference choices
  typedef enum logic [1:0] {
    DACBUF_REF_INTERNAL = 2'h0,
    DACBUF_REF_SUPPLY = 2'h1,
    DACBUF_REF_EXTERNAL = 2'h2
  } dacbuf_ref_t;

  // Internal data buffer state
  typedef enum logic {
    DACBUF_BUF_EMPTY = 1'b0,
    DACBUF_BUF_FULL = 1'b1
  } dacbuf_buf_t;

endpackage

// *** shared/dacbuf_if.sv ***
// Purpose: Carrier between register front end and data path
// Assumes: Single clock domain
// Notes: ctl drives requests, dp returns state and event pulses
`timescale 1ns/1ps
`default_nettype none

interface dacbuf_if;
  logic soft_clr;
  logic enable;
  logic start_evt;
  logic data_wr;
  logic staged_value_buffer_wr;
  logic empty_clr;
  logic [dacbuf_pkg::DATA_W-1:0] wdata;
  logic [dacbuf_pkg::DATA_W-1:0] live_data;
  logic [dacbuf_pkg::DATA_W-1:0] staged_data;
  logic buf_full;
  logic conv_start;
  logic dma_req;
  logic empty_evt;
  logic underrun_evt;

  modport ctl (
    output soft_clr, enable, start_evt, data_wr, staged_value_buffer_wr, empty_clr,
    output wdata,
    input live_data, staged_data, buf_full, conv_start, dma_req,
    input empty_evt, underrun_evt
  );

  modport dp (
    input soft_clr, enable, start_evt, data_wr, staged_value_buffer_wr, empty_clr,
    input wdata,
    output live_data, staged_data, buf_full, conv_start, dma_req,
    output empty_evt, underrun_evt
  );
endinterface

`default_nettype wire

// *** verilog/dacbuf_datapath.sv ***
// Purpose: Live data, staged buffer, conversion start and DMA request
// Assumes: Requests from the front end are one-cycle pulses
// Notes: Event outputs are registered one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module dacbuf_datapath (
  input wire logic clock_i,
  input wire logic rstn_i,
  dacbuf_if.dp ctl
);

  dacbuf_pkg::dacbuf_buf_t buf_state_ff;
  logic [dacbuf_pkg::DATA_W-1:0] live_ff;
  logic [dacbuf_pkg::DATA_W-1:0] staged_ff;
  logic en_d_ff;
  logic conv_ff;
  logic dma_ff;
  logic empty_evt_ff;
  logic underrun_evt_ff;
  logic consume;
  logic en_rise;
  logic starved;

  // Start event takes the pending value, or finds none
  assign consume = ctl.enable && ctl.start_evt
                   && (buf_state_ff == dacbuf_pkg::DACBUF_BUF_FULL);
  assign starved = ctl.enable && ctl.start_evt
                   && (buf_state_ff == dacbuf_pkg::DACBUF_BUF_EMPTY);
  assign en_rise = ctl.enable && !en_d_ff;

  // Internal buffer occupancy
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buf_state_ff <= dacbuf_pkg::DACBUF_BUF_EMPTY;
    end else if (ctl.soft_clr) begin
      buf_state_ff <= dacbuf_pkg::DACBUF_BUF_EMPTY;
    end else if (ctl.staged_value_buffer_wr) begin
      buf_state_ff <= dacbuf_pkg::DACBUF_BUF_FULL;
    end else if (consume) begin
      buf_state_ff <= dacbuf_pkg::DACBUF_BUF_EMPTY;
    end
  end

  // Staged value and live value
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      staged_ff <= dacbuf_pkg::DATA_RESET;
      live_ff <= dacbuf_pkg::DATA_RESET;
    end else if (ctl.soft_clr) begin
      staged_ff <= dacbuf_pkg::DATA_RESET;
      live_ff <= dacbuf_pkg::DATA_RESET;
    end else begin
      if (ctl.staged_value_buffer_wr) begin
        staged_ff <= ctl.wdata;
      end
      if (ctl.data_wr) begin
        live_ff <= ctl.wdata;
      end else if (consume) begin
        live_ff <= staged_ff;
      end
    end
  end

  // Conversion start and event pulses
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_d_ff <= 1'b0;
      conv_ff <= 1'b0;
      empty_evt_ff <= 1'b0;
      underrun_evt_ff <= 1'b0;
    end else begin
      en_d_ff <= ctl.enable && !ctl.soft_clr;
      conv_ff <= ctl.enable && (ctl.data_wr || consume);
      empty_evt_ff <= consume || (en_rise
                      && buf_state_ff == dacbuf_pkg::DACBUF_BUF_EMPTY);
      underrun_evt_ff <= starved;
    end
  end

  // Buffer-empty DMA request, set wins over clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dma_ff <= 1'b0;
    end else if (ctl.soft_clr || !ctl.enable) begin
      dma_ff <= 1'b0;
    end else if (consume || (en_rise
                 && buf_state_ff == dacbuf_pkg::DACBUF_BUF_EMPTY)) begin
      dma_ff <= 1'b1;
    end else if (ctl.staged_value_buffer_wr || ctl.empty_clr) begin
      dma_ff <= 1'b0;
    end
  end

  assign ctl.live_data = live_ff;
  assign ctl.staged_data = staged_ff;
  assign ctl.buf_full = (buf_state_ff == dacbuf_pkg::DACBUF_BUF_FULL);
  assign ctl.conv_start = conv_ff;
  assign ctl.dma_req = dma_ff;
  assign ctl.empty_evt = empty_evt_ff;
  assign ctl.underrun_evt = underrun_evt_ff;

endmodule

`default_nettype wire

// *** verilog/dacbuf_top.sv ***
// Purpose: Register front end and pin outputs of the buffered DAC control
// Assumes: APB-style bus, zero wait states, synchronous inputs
// Notes: Read data is captured in the setup phase
`timescale 1ns/1ps
`default_nettype none

module dacbuf_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dacbuf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [dacbuf_pkg::BUS_W-1:0] pwdata_i,
  output logic [dacbuf_pkg::BUS_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic start_evt_i,
  output logic [dacbuf_pkg::DATA_W-1:0] dac_code_o,
  output logic conv_start_o,
  output logic out_drive_en_o,
  output logic [1:0] ref_select_o,
  output logic dma_req_o,
  output logic irq_o
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Address match against a register offset
  function automatic logic hit(input logic [dacbuf_pkg::ADDR_W-1:0] a,
                               input logic [dacbuf_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Known register address
  function automatic logic mapped(input logic [dacbuf_pkg::ADDR_W-1:0] a);
    mapped = hit(a, dacbuf_pkg::OFF_CONTROL_A)
             || hit(a, dacbuf_pkg::OFF_INTEN_CLEAR)
             || hit(a, dacbuf_pkg::OFF_INTEN_SET)
             || hit(a, dacbuf_pkg::OFF_INT_FLAGS)
             || hit(a, dacbuf_pkg::OFF_CONTROL_B)
             || hit(a, dacbuf_pkg::OFF_LIVE_DATA)
             || hit(a, dacbuf_pkg::OFF_STAGED_BUF);
  endfunction

  // ************************************************************
  // State
  // ************************************************************

  // Carrier to the data path
  dacbuf_if link ();

  logic enable_ff;
  logic external_output_enable_ff;
  logic [1:0] reference_select_ff;
  logic [dacbuf_pkg::INT_W-1:0] inten_ff;
  logic [dacbuf_pkg::INT_W-1:0] flag_ff;
  logic [dacbuf_pkg::INT_W-1:0] nxt_flag;
  logic [dacbuf_pkg::INT_W-1:0] set_evt;
  logic [dacbuf_pkg::BUS_W-1:0] prdata_ff;
  logic [dacbuf_pkg::BUS_W-1:0] rd_mux;
  logic pready_ff;
  logic pslverr_ff;
  logic out_en_ff;
  logic [1:0] ref_ff;
  logic irq_ff;
  logic setup_ph;
  logic wr_acc;
  logic soft_clr;
  logic [dacbuf_pkg::INT_W-1:0] wbits;
  logic wr_ctla;
  logic wr_ctlb;
  logic wr_set;
  logic wr_clr;
  logic wr_flags;
  logic wr_live;
  logic wr_buf;

  assign setup_ph = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign wbits = pwdata_i[dacbuf_pkg::INT_W-1:0];
  assign soft_clr = wr_ctla
                    && pwdata_i[dacbuf_pkg::CTLA_SOFT_RESET_BIT];

  // ************************************************************
  // Write strobes
  // ************************************************************

  // Access-phase write to each register
  assign wr_ctla = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_CONTROL_A);
  assign wr_ctlb = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_CONTROL_B);
  assign wr_set = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_INTEN_SET);
  assign wr_clr = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_INTEN_CLEAR);
  assign wr_flags = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_INT_FLAGS);
  assign wr_live = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_LIVE_DATA);
  assign wr_buf = wr_acc && hit(paddr_i, dacbuf_pkg::OFF_STAGED_BUF);

  // ************************************************************
  // Requests to the data path
  // ************************************************************

  // Bus or DMA writes of data and staged buffer
  assign link.soft_clr = soft_clr;
  assign link.enable = enable_ff;
  assign link.start_evt = start_evt_i;
  assign link.wdata = pwdata_i[dacbuf_pkg::DATA_W-1:0];
  assign link.data_wr = wr_live;
  assign link.staged_value_buffer_wr = wr_buf;
  assign link.empty_clr = wr_flags
                          && pwdata_i[dacbuf_pkg::INT_EMPTY_BIT];

  // Data path: live value, staged buffer and request
  dacbuf_datapath u_datapath (
    .clock_i (clock_i),
    .rstn_i (rstn_i),
    .ctl (link.dp)
  );

  // ************************************************************
  // Control registers
  // ************************************************************

  // Control A enable; soft reset self-clears
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_ff <= 1'b0;
    end else if (soft_clr) begin
      enable_ff <= 1'b0;
    end else if (wr_ctla) begin
      enable_ff <= pwdata_i[dacbuf_pkg::CTLA_ENABLE_BIT];
    end
  end

  // Control B output enable
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      external_output_enable_ff <= 1'b0;
    end else if (soft_clr) begin
      external_output_enable_ff <= 1'b0;
    end else if (wr_ctlb) begin
      external_output_enable_ff <= pwdata_i[dacbuf_pkg::CTLB_EXTERNAL_OUTPUT_ENABLE_BIT];
    end
  end

  // Control B reference select; internal after any reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reference_select_ff <= dacbuf_pkg::DACBUF_REF_INTERNAL;
    end else if (soft_clr) begin
      reference_select_ff <= dacbuf_pkg::DACBUF_REF_INTERNAL;
    end else if (wr_ctlb) begin
      reference_select_ff <= pwdata_i[dacbuf_pkg::CTLB_REFERENCE_SELECT_LSB +: 2];
    end
  end

  // Shared enable state behind set and clear views
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inten_ff <= dacbuf_pkg::INT_RESET;
    end else if (soft_clr) begin
      inten_ff <= dacbuf_pkg::INT_RESET;
    end else if (wr_set) begin
      inten_ff <= inten_ff | wbits;
    end else if (wr_clr) begin
      inten_ff <= inten_ff & ~wbits;
    end
  end

  // ************************************************************
  // Interrupt flags
  // ************************************************************

  // Events from the data path
  always_comb begin
    set_evt = dacbuf_pkg::INT_RESET;
    set_evt[dacbuf_pkg::INT_EMPTY_BIT] = link.empty_evt;
    set_evt[dacbuf_pkg::INT_UNDERRUN_BIT] = link.underrun_evt;
  end

  // Write one clears; a same-cycle event wins
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_flags) begin
      nxt_flag = flag_ff & ~wbits;
    end
    nxt_flag = nxt_flag | set_evt;
  end

  // Flag register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_ff <= dacbuf_pkg::INT_RESET;
    end else if (soft_clr) begin
      flag_ff <= dacbuf_pkg::INT_RESET;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************

  // Read multiplexer
  always_comb begin
    rd_mux = dacbuf_pkg::BUS_ZERO;
    if (hit(paddr_i, dacbuf_pkg::OFF_CONTROL_A)) begin
      rd_mux[dacbuf_pkg::CTLA_ENABLE_BIT] = enable_ff;
    end else if (hit(paddr_i, dacbuf_pkg::OFF_INTEN_CLEAR)
                 || hit(paddr_i, dacbuf_pkg::OFF_INTEN_SET)) begin
      rd_mux[dacbuf_pkg::INT_W-1:0] = inten_ff;
    end else if (hit(paddr_i, dacbuf_pkg::OFF_INT_FLAGS)) begin
      rd_mux[dacbuf_pkg::INT_W-1:0] = flag_ff;
    end else if (hit(paddr_i, dacbuf_pkg::OFF_CONTROL_B)) begin
      rd_mux[dacbuf_pkg::CTLB_EXTERNAL_OUTPUT_ENABLE_BIT] = external_output_enable_ff;
      rd_mux[dacbuf_pkg::CTLB_REFERENCE_SELECT_LSB +: 2] = reference_select_ff;
    end else if (hit(paddr_i, dacbuf_pkg::OFF_LIVE_DATA)) begin
      rd_mux[dacbuf_pkg::DATA_W-1:0] = link.live_data;
    end else if (hit(paddr_i, dacbuf_pkg::OFF_STAGED_BUF)) begin
      rd_mux[dacbuf_pkg::DATA_W-1:0] = link.staged_data;
    end
  end

  // Read data captured in the setup phase, held through access
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_ff <= dacbuf_pkg::BUS_ZERO;
    end else if (setup_ph) begin
      prdata_ff <= pwrite_i ? dacbuf_pkg::BUS_ZERO : rd_mux;
    end
  end

  // Error for an unmapped address, same timing as read data
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      pslverr_ff <= !mapped(paddr_i);
    end
  end

  // No wait states: ready stays high
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_ff <= 1'b1;
    end else begin
      pready_ff <= 1'b1;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************

  // Driver enable follows the control B bit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_en_ff <= 1'b0;
    end else begin
      out_en_ff <= external_output_enable_ff && !soft_clr;
    end
  end

  // Reference select to the analog side
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_ff <= dacbuf_pkg::DACBUF_REF_INTERNAL;
    end else if (soft_clr) begin
      ref_ff <= dacbuf_pkg::DACBUF_REF_INTERNAL;
    end else begin
      ref_ff <= reference_select_ff;
    end
  end

  // Interrupt line; soft reset drops it at once
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ff <= 1'b0;
    end else if (soft_clr) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flag_ff & inten_ff);
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign dac_code_o = link.live_data;
  assign conv_start_o = link.conv_start;
  assign out_drive_en_o = out_en_ff;
  assign ref_select_o = ref_ff;
  assign dma_req_o = link.dma_req;
  assign irq_o = irq_ff;

endmodule

`default_nettype wire

// *** sim/dacbuf_top_props.sv ***
// Purpose: Port-level checks for the buffered DAC control
// Assumes: One clock domain, bound to dacbuf_top
// Notes: Sees top ports only
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module dacbuf_props (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dacbuf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [dacbuf_pkg::BUS_W-1:0] pwdata_i,
  input wire logic start_evt_i,
  input wire logic [dacbuf_pkg::DATA_W-1:0] dac_code_o,
  input wire logic conv_start_o,
  input wire logic out_drive_en_o,
  input wire logic [1:0] ref_select_o,
  input wire logic dma_req_o,
  input wire logic irq_o,
  input wire logic pslverr_o
);
  logic wr;
  logic wr_a;
  logic wr_b;
  logic wr_live;
  logic wr_buf;
  logic wr_flg;
  // Access-phase write decode
  assign wr = psel_i & penable_i & pwrite_i;
  assign wr_a = wr && paddr_i == dacbuf_pkg::OFF_CONTROL_A;
  assign wr_b = wr && paddr_i == dacbuf_pkg::OFF_CONTROL_B;
  assign wr_live = wr && paddr_i == dacbuf_pkg::OFF_LIVE_DATA;
  assign wr_buf = wr && paddr_i == dacbuf_pkg::OFF_STAGED_BUF;
  assign wr_flg = wr && paddr_i == dacbuf_pkg::OFF_INT_FLAGS;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  chk_soft_reset_all: assert property (
    wr_a && pwdata_i[0] |=> !dma_req_o && !out_drive_en_o && !irq_o
      && dac_code_o == 10'h000) else $error("soft reset left state");
  chk_drive_en_bit: assert property (
    wr_b |=> ##1 out_drive_en_o == $past(pwdata_i[0], 2))
    else $error("driver enable mismatch");
  chk_ref_select: assert property (
    wr_b |=> ##1 ref_select_o == $past(pwdata_i[3:2], 2))
    else $error("reference select mismatch");
  chk_live_load: assert property (
    wr_live |=> dac_code_o == $past(pwdata_i[9:0]))
    else $error("live data not loaded");
  chk_conv_cause: assert property (
    conv_start_o |-> $past(start_evt_i) || $past(wr_live))
    else $error("conversion without a load");
  chk_fill_drops_dma: assert property (
    wr_buf && !start_evt_i |=> !dma_req_o)
    else $error("request kept after fill");
  chk_flag_drops_dma: assert property (
    wr_flg && pwdata_i[1] && !start_evt_i |=> !dma_req_o)
    else $error("request kept after flag clear");
  chk_consume_dma: assert property (
    conv_start_o && !$past(wr_live) |-> dma_req_o)
    else $error("no request after consume");
  cov_conv: cover property (conv_start_o);
  cov_irq: cover property ($rose(irq_o));
  cov_err: cover property (pslverr_o);
endmodule
bind dacbuf_top dacbuf_props chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .start_evt_i(start_evt_i),
  .dac_code_o(dac_code_o), .conv_start_o(conv_start_o),
  .out_drive_en_o(out_drive_en_o), .ref_select_o(ref_select_o),
  .dma_req_o(dma_req_o), .irq_o(irq_o), .pslverr_o(pslverr_o));
`default_nettype wire

// *** sim/dacbuf_bus_model.sv ***
// Purpose: Peripheral bus master standing for the processor or DMA
// Assumes: Two-cycle transfers, inputs driven at the falling edge
// Notes: One transfer at a time, idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module dacbuf_bus_model (
  input wire logic clock_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [dacbuf_pkg::ADDR_W-1:0] paddr_o,
  output logic [dacbuf_pkg::BUS_W-1:0] pwdata_o,
  input wire logic [dacbuf_pkg::BUS_W-1:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'hFF;
    pwdata_o = 32'h0000_0000;
  end
  // Single master, never overlaps a request source access
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(negedge clock_i);
    psel_o = 1'b1;
    pwrite_o = w;
    paddr_o = a;
    pwdata_o = d;
    @(negedge clock_i);
    penable_o = 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    @(negedge clock_i);
    // Released lines show a changed pattern
    psel_o = 1'b0;
    penable_o = 1'b0;
    paddr_o = ~a;
    pwdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// *** sim/test_dac_buffered_update_control.sv ***
// Purpose: Self-checking bench for the buffered DAC control
// Assumes: 50 MHz clock, bus model drives the register port
// Notes: Conversion spacing is a bench choice
`timescale 1ns/1ps
`default_nettype none
module test_dac_buffered_update_control;
  localparam int CONV_CYC = 4;
  logic clock_i;
  logic rstn_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic start_evt;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic [9:0] dac_code;
  logic conv_start;
  logic drive_en;
  logic dma_req;
  logic irq;
  logic [1:0] ref_sel;
  logic [31:0] codes [2] = '{32'h0000_0155, 32'h0000_06AA};
  int fails;
  int num_checks;
  dacbuf_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .start_evt_i(start_evt), .dac_code_o(dac_code),
    .conv_start_o(conv_start), .out_drive_en_o(drive_en),
    .ref_select_o(ref_sel), .dma_req_o(dma_req), .irq_o(irq));
  dacbuf_bus_model bus (.clock_i(clock_i), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  task automatic stop_test;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    bus.xfer(1'b0, a, 32'h0000_0000, rd, err);
    cmp(rd & m, exp);
  endtask
  task automatic pulse_start;
    @(negedge clock_i);
    start_evt = 1'b1;
    @(negedge clock_i);
    start_evt = 1'b0;
  endtask
  // Clock generator
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clock_i);
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    start_evt = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    rd_chk(dacbuf_pkg::OFF_INTEN_CLEAR, 32'hFF, 32'h0);
    wr(dacbuf_pkg::OFF_INTEN_SET, 32'h3);
    rd_chk(dacbuf_pkg::OFF_INTEN_CLEAR, 32'hFF, 32'h3);
    wr(dacbuf_pkg::OFF_INTEN_CLEAR, 32'h1);
    rd_chk(dacbuf_pkg::OFF_INTEN_SET, 32'hFF, 32'h2);
    wr(dacbuf_pkg::OFF_INTEN_CLEAR, 32'h0);
    rd_chk(dacbuf_pkg::OFF_INTEN_CLEAR, 32'hFF, 32'h2);
    for (int r = 0; r < 3; r++) begin
      wr(dacbuf_pkg::OFF_CONTROL_B, 32'(r * 4 + 1));
      // Pins follow the register one cycle later
      @(negedge clock_i);
      cmp(32'(ref_sel), 32'(r));
      cmp(32'(drive_en), 32'h1);
    end
    wr(dacbuf_pkg::OFF_CONTROL_B, 32'h0);
    @(negedge clock_i);
    cmp(32'(drive_en), 32'h0);
    wr(dacbuf_pkg::OFF_CONTROL_A, 32'h2);
    repeat (3) @(negedge clock_i);
    cmp(32'(dma_req), 32'h1);
    rd_chk(dacbuf_pkg::OFF_INT_FLAGS, 32'h2, 32'h2);
    cmp(32'(irq), 32'h1);
    wr(dacbuf_pkg::OFF_STAGED_BUF, 32'h3FF);
    cmp(32'(dma_req), 32'h0);
    pulse_start();
    cmp(32'(dac_code), 32'h3FF);
    cmp(32'(conv_start), 32'h1);
    cmp(32'(dma_req), 32'h1);
    wr(dacbuf_pkg::OFF_INT_FLAGS, 32'h3);
    cmp(32'(dma_req), 32'h0);
    pulse_start();
    cmp(32'(conv_start), 32'h0);
    cmp(32'(dac_code), 32'h3FF);
    repeat (3) @(negedge clock_i);
    rd_chk(dacbuf_pkg::OFF_INT_FLAGS, 32'h1, 32'h1);
    cmp(32'(irq), 32'h0);
    wr(dacbuf_pkg::OFF_INTEN_SET, 32'h1);
    @(negedge clock_i);
    cmp(32'(irq), 32'h1);
    wr(dacbuf_pkg::OFF_INTEN_CLEAR, 32'h3);
    repeat (2) @(negedge clock_i);
    cmp(32'(irq), 32'h0);
    foreach (codes[i]) begin
      repeat (CONV_CYC) @(negedge clock_i);
      wr(dacbuf_pkg::OFF_LIVE_DATA, codes[i]);
      cmp(32'(dac_code), codes[i] & 32'h3FF);
      cmp(32'(conv_start), 32'h1);
    end
    bus.xfer(1'b0, 8'h1C, 32'h0000_0000, rd, err);
    cmp(rd, 32'h0);
    cmp(32'(err), 32'h1);
    cmp(32'(pready), 32'h1);
    wr(dacbuf_pkg::OFF_CONTROL_B, 32'h9);
    wr(dacbuf_pkg::OFF_INTEN_SET, 32'h3);
    wr(dacbuf_pkg::OFF_CONTROL_A, 32'h1);
    cmp(32'(drive_en), 32'h0);
    cmp(32'(dac_code), 32'h0);
    cmp(32'(dma_req), 32'h0);
    cmp(32'(irq), 32'h0);
    cmp(32'(ref_sel), 32'h0);
    rd_chk(dacbuf_pkg::OFF_INTEN_CLEAR, 32'hFF, 32'h0);
    rd_chk(dacbuf_pkg::OFF_CONTROL_A, 32'h3, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
